// [common/flash_regs_pkg.sv]
package flash_regs_pkg;

    typedef struct packed {
        logic       status_write_lock;
        logic       prog_error;
        logic       erase_error;
        logic [2:0] protect_range;
        logic       write_enable_latch;
        logic       busy_flag;
    } status_t;

    typedef struct packed {
        logic [1:0] latency_code;
        logic       protect_start_select;
        logic       reserved;
        logic       protect_bits_volatility;
        logic       param_sector_location;
        logic       quad_mode;
        logic       freeze_lock;
    } config_t;

    typedef struct packed {
        logic start;
        logic erase;
    } op_req_t;

    typedef enum logic [1:0] {
        FRAME_IDLE   = 2'b00,
        FRAME_OPCODE = 2'b01,
        FRAME_ARGS   = 2'b10
    } frame_state_t;

    typedef enum logic [1:0] {
        READ_NONE   = 2'b00,
        READ_STATUS = 2'b01,
        READ_CONFIG = 2'b10,
        READ_ID_MAP = 2'b11
    } read_sel_t;

    localparam logic [7:0] OP_REGISTER_WRITE     = 8'h01;
    localparam logic [7:0] OP_PAGE_PROGRAM       = 8'h02;
    localparam logic [7:0] OP_CLEAR_WRITE_LATCH  = 8'h04;
    localparam logic [7:0] OP_READ_STATUS        = 8'h05;
    localparam logic [7:0] OP_SET_WRITE_LATCH    = 8'h06;
    localparam logic [7:0] OP_CLEAR_STATUS       = 8'h30;
    localparam logic [7:0] OP_READ_CONFIG        = 8'h35;
    localparam logic [7:0] OP_READ_ID            = 8'h9f;
    localparam logic [7:0] OP_SECTOR_ERASE       = 8'hd8;
    localparam logic [7:0] OP_SOFT_RESET         = 8'hf0;

    localparam status_t    STATUS_RESET           = 8'h00;
    localparam config_t    CONFIG_RESET           = 8'h00;
    localparam logic [2:0] PROTECT_VOLATILE_RESET = 3'h7;
    localparam logic [2:0] PROTECT_ALL            = 3'h7;
    localparam logic [2:0] PROTECT_NONE           = 3'h0;
    localparam logic [2:0] SYNC_RESET             = 3'h6;

    localparam logic [7:0] PAD_PARAM_ID   = 8'hf0;
    localparam logic [7:0] PAD_FILL       = 8'hff;
    localparam logic [7:0] PAD_LEN_FIRST  = 8'h0f;
    localparam logic [7:0] PAD_LEN_SECOND = 8'h03;

    localparam logic [2:0] LAST_BIT  = 3'h7;
    localparam logic [1:0] MAX_ARGS  = 2'h3;
    localparam logic [1:0] ARGS_CFG  = 2'h2;

    localparam int CLK_PERIOD_NS         = 20;
    localparam int REG_WRITE_BUSY_NS     = 2000;
    localparam int REG_WRITE_BUSY_CYCLES = (REG_WRITE_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ARRAY_ADDR_W          = 24;

endpackage : flash_regs_pkg

// [design/flash_cdc_sync.sv]
`timescale 1ns/1ps
module flash_cdc_sync #(
    parameter int               WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // The first stage feeds only the second one
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_ff <= RESET_VALUE;
            sync_ff <= RESET_VALUE;
        end
        else if (ce)
        begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;

endmodule : flash_cdc_sync

// [design/flash_link_shifter.sv]
`timescale 1ns/1ps
module flash_link_shifter (
    input  wire logic                    sck,
    input  wire logic                    rst,
    input  wire logic                    cs_n,
    input  wire logic                    mosi,
    input  wire flash_regs_pkg::status_t status_view,
    input  wire flash_regs_pkg::config_t config_view,
    output logic                         miso,
    output logic [7:0]                   rx_byte,
    output logic                         rx_toggle
);
    import flash_regs_pkg::*;

    logic [2:0]  bit_cnt_ff;
    logic [6:0]  shift_ff;
    logic [7:0]  byte_idx_ff;
    read_sel_t   read_sel_ff;
    logic [6:0]  out_ff;
    logic        miso_ff;
    logic [7:0]  rx_byte_ff;
    logic        rx_toggle_ff;
    logic [15:0] view_sync;
    logic [7:0]  rx_full;
    logic [7:0]  tx_byte;

    // Map of two pad parameters, each with its own length, then erased fill
    function automatic logic [7:0] id_map_byte(input logic [7:0] idx);
        logic [7:0] second;
        second = PAD_LEN_FIRST + 8'h02;
        if (idx == 8'h00 || idx == second)
            id_map_byte = PAD_PARAM_ID;
        else if (idx == 8'h01)
            id_map_byte = PAD_LEN_FIRST;
        else if (idx == second + 8'h01)
            id_map_byte = PAD_LEN_SECOND;
        else
            id_map_byte = PAD_FILL;
    endfunction : id_map_byte

    assign rx_full = {shift_ff, mosi};

    flash_cdc_sync #(
        .WIDTH       (16),
        .RESET_VALUE (16'h0000)
    ) u_view_sync (
        .clk (sck),
        .rst (rst),
        .ce  (1'b1),
        .d   ({status_view, config_view}),
        .q   (view_sync)
    );

    // The frame ends with chip select; no sck edge is needed to clear it
    always_ff @(posedge sck or posedge cs_n or posedge rst)
    begin
        if (rst || cs_n)
        begin
            bit_cnt_ff  <= 3'h0;
            byte_idx_ff <= 8'h00;
            read_sel_ff <= READ_NONE;
        end
        else
        begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == LAST_BIT)
            begin
                if (byte_idx_ff != 8'hff)
                    byte_idx_ff <= byte_idx_ff + 8'h01;
                if (byte_idx_ff == 8'h00)
                begin
                    case (rx_full)
                        OP_READ_STATUS: read_sel_ff <= READ_STATUS;
                        OP_READ_CONFIG: read_sel_ff <= READ_CONFIG;
                        OP_READ_ID:     read_sel_ff <= READ_ID_MAP;
                        default:        read_sel_ff <= READ_NONE;
                    endcase
                end
            end
        end
    end

    // Byte held stable for a whole byte time while the toggle crosses
    always_ff @(posedge sck or posedge rst)
    begin
        if (rst)
        begin
            shift_ff     <= 7'h00;
            rx_byte_ff   <= 8'h00;
            rx_toggle_ff <= 1'b0;
        end
        else
        begin
            shift_ff <= rx_full[6:0];
            if (bit_cnt_ff == LAST_BIT)
            begin
                rx_byte_ff   <= rx_full;
                rx_toggle_ff <= ~rx_toggle_ff;
            end
        end
    end

    always_comb
    begin
        case (read_sel_ff)
            READ_STATUS: tx_byte = view_sync[15:8];
            READ_CONFIG: tx_byte = view_sync[7:0];
            READ_ID_MAP: tx_byte = id_map_byte(byte_idx_ff - 8'h01);
            default:     tx_byte = PAD_FILL;
        endcase
    end

    always_ff @(negedge sck or posedge cs_n or posedge rst)
    begin
        if (rst || cs_n)
        begin
            miso_ff <= 1'b0;
            out_ff  <= 7'h00;
        end
        else if (bit_cnt_ff == 3'h0 && byte_idx_ff != 8'h00)
            {miso_ff, out_ff} <= tx_byte;
        else
            {miso_ff, out_ff} <= {out_ff, 1'b0};
    end

    assign miso      = miso_ff;
    assign rx_byte   = rx_byte_ff;
    assign rx_toggle = rx_toggle_ff;

endmodule : flash_link_shifter

// [design/flash_status_config_regs.sv]
`timescale 1ns/1ps
// Overview of operation
// - Identification map may hold pad parameters repeatedly, each with its own length.
// - Lock bit set with write-protect pin low makes register writes ignored.
// - Status bit 6 flags a program failure; volatile, read-only, reset clears it.
// - Status bit 5 flags an erase failure; volatile, read-only, reset clears it.
// - Status bits 4..2 shield sectors; volatile when config bit 3 set.
// - Write latch must be set before register write, program or erase run.
// - Only set-latch and clear-latch commands change the write latch.
// - Status bit 0 reads one while any write, program or erase runs.
// - Config bits 7..6 hold the read latency code, default zero.
// - Config bit 5, one-time, puts the protected range at low addresses.
// - Config bit 3, one-time, makes the protection bits volatile.
// - Config bit 2, one-time, puts parameter sectors at the top.
// - Config bit 1 selects four-lane operation, else dual or single.
// - Config bit 0 freezes protection bits and one-time bits 5 and 2, not bit 3, until reset.
module flash_status_config_regs #(
    parameter int   BUSY_CYCLES     = flash_regs_pkg::REG_WRITE_BUSY_CYCLES,
    parameter int   ADDR_W          = flash_regs_pkg::ARRAY_ADDR_W,
    parameter logic UNIFORM_SECTORS = 1'b0
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    ce,
    input  wire logic                    sck,
    input  wire logic                    cs_n,
    input  wire logic                    mosi,
    input  wire logic                    wp_n,
    input  wire logic                    array_busy,
    input  wire logic                    prog_fail,
    input  wire logic                    erase_fail,
    output logic                         miso,
    output flash_regs_pkg::status_t      status_out,
    output flash_regs_pkg::config_t      config_out,
    output flash_regs_pkg::op_req_t      op_req,
    output logic [ADDR_W-1:0]            op_addr
);
    import flash_regs_pkg::*;

    localparam int CNT_W = $clog2(BUSY_CYCLES + 1);

    logic [2:0]        pin_sync;
    logic              cs_n_sync;
    logic              wp_n_sync;
    logic              tgl_sync;
    logic [7:0]        rx_byte;
    logic              rx_toggle;
    logic              cs_seen_ff;
    logic              tgl_seen_ff;
    frame_state_t      frame_ff;
    logic [7:0]        cmd_ff;
    logic [1:0]        arg_cnt_ff;
    logic [7:0]        arg_ff [3];
    logic              wel_ff;
    logic [CNT_W-1:0]  busy_cnt_ff;
    logic              busy_ff;
    logic              lock_ff;
    logic [2:0]        bp_ff;
    logic              perr_ff;
    logic              eerr_ff;
    config_t           cfg_ff;
    status_t           status_view_ff;
    config_t           config_view_ff;
    op_req_t           op_req_ff;
    logic [ADDR_W-1:0] op_addr_ff;
    status_t           stat_arg;
    config_t           cfg_arg;
    logic [ADDR_W-1:0] arg_addr;
    logic              byte_evt;
    logic              frame_start;
    logic              frame_end;
    logic              exec;
    logic              hw_locked;
    logic              reg_write_go;
    logic              config_write_go;
    logic              soft_reset_go;
    logic              clear_status_go;
    logic              array_cmd;
    logic              array_allowed;
    logic              addr_guarded;
    logic              op_go;
    logic              op_refused;

    function automatic logic cmd_run(input logic go, input logic [7:0] cmd, input logic [7:0] op);
        return go && (cmd == op);
    endfunction : cmd_run

    // Range grows from one 64th of the array up to all of it
    function automatic logic in_protected(input logic [ADDR_W-1:0] addr, input logic [2:0] bp,
                                          input logic from_bottom);
        logic hit;
        hit = 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            if (i < int'(PROTECT_ALL - bp))
                hit = hit && (addr[ADDR_W-1-i] == !from_bottom);
        end
        if (bp == PROTECT_NONE)
            in_protected = 1'b0;
        else if (bp == PROTECT_ALL)
            in_protected = 1'b1;
        else
            in_protected = hit;
    endfunction : in_protected

    flash_cdc_sync #(
        .WIDTH       (3),
        .RESET_VALUE (SYNC_RESET)
    ) u_pin_sync (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .d   ({cs_n, wp_n, rx_toggle}),
        .q   (pin_sync)
    );

    flash_link_shifter u_link (
        .sck         (sck),
        .rst         (rst),
        .cs_n        (cs_n),
        .mosi        (mosi),
        .status_view (status_view_ff),
        .config_view (config_view_ff),
        .miso        (miso),
        .rx_byte     (rx_byte),
        .rx_toggle   (rx_toggle)
    );

    assign {cs_n_sync, wp_n_sync, tgl_sync} = pin_sync;
    assign stat_arg = status_t'(arg_ff[0]);
    assign cfg_arg  = config_t'(arg_ff[1]);
    assign arg_addr = ADDR_W'({arg_ff[0], arg_ff[1], arg_ff[2]});

    assign byte_evt    = tgl_sync ^ tgl_seen_ff;
    assign frame_start = cs_seen_ff & ~cs_n_sync;
    assign frame_end   = ~cs_seen_ff & cs_n_sync;
    // Commands act only when chip select rises, as a whole frame
    assign exec        = frame_end && (frame_ff == FRAME_ARGS);

    assign hw_locked       = lock_ff && !wp_n_sync;
    assign reg_write_go    = cmd_run(exec, cmd_ff, OP_REGISTER_WRITE) && (arg_cnt_ff != 2'h0)
                             && wel_ff && !busy_ff && !hw_locked;
    assign config_write_go = reg_write_go && (arg_cnt_ff >= ARGS_CFG);
    assign soft_reset_go   = cmd_run(exec, cmd_ff, OP_SOFT_RESET) && !busy_ff;
    assign clear_status_go = cmd_run(exec, cmd_ff, OP_CLEAR_STATUS) && !busy_ff;

    assign array_cmd     = cmd_run(exec, cmd_ff, OP_PAGE_PROGRAM) || cmd_run(exec, cmd_ff, OP_SECTOR_ERASE);
    assign array_allowed = array_cmd && wel_ff && !busy_ff && (arg_cnt_ff == MAX_ARGS);
    assign addr_guarded  = in_protected(arg_addr, bp_ff, cfg_ff.protect_start_select);
    assign op_go         = array_allowed && !addr_guarded;
    assign op_refused    = array_allowed && addr_guarded;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cs_seen_ff  <= 1'b1;
            tgl_seen_ff <= 1'b0;
        end
        else if (ce)
        begin
            cs_seen_ff  <= cs_n_sync;
            tgl_seen_ff <= tgl_sync;
        end
    end

    // Argument bytes past the third are dummies of a read and are dropped
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            frame_ff   <= FRAME_IDLE;
            cmd_ff     <= 8'h00;
            arg_cnt_ff <= 2'h0;
            arg_ff[0]  <= 8'h00;
            arg_ff[1]  <= 8'h00;
            arg_ff[2]  <= 8'h00;
        end
        else if (ce)
        begin
            case (frame_ff)
                FRAME_IDLE:
                begin
                    if (frame_start)
                    begin
                        frame_ff   <= FRAME_OPCODE;
                        arg_cnt_ff <= 2'h0;
                    end
                end
                FRAME_OPCODE:
                begin
                    if (frame_end)
                        frame_ff <= FRAME_IDLE;
                    else if (byte_evt)
                    begin
                        cmd_ff   <= rx_byte;
                        frame_ff <= FRAME_ARGS;
                    end
                end
                FRAME_ARGS:
                begin
                    if (frame_end)
                        frame_ff <= FRAME_IDLE;
                    else if (byte_evt && arg_cnt_ff != MAX_ARGS)
                    begin
                        arg_ff[arg_cnt_ff] <= rx_byte;
                        arg_cnt_ff         <= arg_cnt_ff + 2'h1;
                    end
                end
                default:
                    frame_ff <= FRAME_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            wel_ff <= 1'b0;
        else if (ce)
        begin
            if (cmd_run(exec, cmd_ff, OP_CLEAR_WRITE_LATCH))
                wel_ff <= 1'b0;
            else if (cmd_run(exec, cmd_ff, OP_SET_WRITE_LATCH) && !busy_ff)
                wel_ff <= 1'b1;
        end
    end

    // Busy covers the register write time and any array operation
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            busy_cnt_ff <= '0;
            busy_ff     <= 1'b0;
        end
        else if (ce)
        begin
            if (reg_write_go)
                busy_cnt_ff <= CNT_W'(BUSY_CYCLES);
            else if (busy_cnt_ff != '0)
                busy_cnt_ff <= busy_cnt_ff - CNT_W'(1);
            busy_ff <= reg_write_go || (busy_cnt_ff > CNT_W'(1)) || array_busy || op_go;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lock_ff <= 1'b0;
            bp_ff   <= PROTECT_NONE;
        end
        else if (ce)
        begin
            if (reg_write_go)
            begin
                lock_ff <= stat_arg.status_write_lock;
                if (!cfg_ff.freeze_lock)
                    bp_ff <= stat_arg.protect_range;
            end
            else if (soft_reset_go && cfg_ff.protect_bits_volatility)
                bp_ff <= PROTECT_VOLATILE_RESET;
        end
    end

    // A failure in the same cycle as a clear still leaves the flag set
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            perr_ff <= 1'b0;
            eerr_ff <= 1'b0;
        end
        else if (ce)
        begin
            if (prog_fail || (op_refused && cmd_ff == OP_PAGE_PROGRAM))
                perr_ff <= 1'b1;
            else if (clear_status_go || soft_reset_go)
                perr_ff <= 1'b0;
            if (erase_fail || (op_refused && cmd_ff == OP_SECTOR_ERASE))
                eerr_ff <= 1'b1;
            else if (clear_status_go || soft_reset_go)
                eerr_ff <= 1'b0;
        end
    end

    // One-time bits only ever go from zero to one
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cfg_ff <= CONFIG_RESET;
        else if (ce)
        begin
            if (config_write_go)
            begin
                cfg_ff.latency_code <= cfg_arg.latency_code;
                cfg_ff.quad_mode    <= cfg_arg.quad_mode;
                cfg_ff.protect_bits_volatility <= cfg_ff.protect_bits_volatility
                                                  | cfg_arg.protect_bits_volatility;
                if (!cfg_ff.freeze_lock)
                begin
                    cfg_ff.protect_start_select <= cfg_ff.protect_start_select
                                                   | cfg_arg.protect_start_select;
                    if (!UNIFORM_SECTORS)
                        cfg_ff.param_sector_location <= cfg_ff.param_sector_location
                                                        | cfg_arg.param_sector_location;
                end
                cfg_ff.freeze_lock <= cfg_ff.freeze_lock | cfg_arg.freeze_lock;
            end
            else if (soft_reset_go)
                cfg_ff.freeze_lock <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            op_req_ff  <= '0;
            op_addr_ff <= '0;
        end
        else if (ce)
        begin
            op_req_ff.start <= op_go;
            op_req_ff.erase <= op_go && (cmd_ff == OP_SECTOR_ERASE);
            if (op_go)
                op_addr_ff <= arg_addr;
        end
    end

    // Registered views feed both the outputs and the link side crossing
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            status_view_ff <= STATUS_RESET;
            config_view_ff <= CONFIG_RESET;
        end
        else if (ce)
        begin
            status_view_ff <= {lock_ff, perr_ff, eerr_ff, bp_ff, wel_ff, busy_ff};
            config_view_ff <= cfg_ff;
        end
    end

    assign status_out = status_view_ff;
    assign config_out = config_view_ff;
    assign op_req     = op_req_ff;
    assign op_addr    = op_addr_ff;

endmodule : flash_status_config_regs

// [bench/flash_host_model.sv]
`timescale 1ns/1ps
module flash_host_model (
    output logic      sck,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    initial
    begin
        sck  = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // Clock stands low between frames; a released data line shows the inverse of its last bit
    task automatic frame(input logic [7:0] tx[$], input int nrd, output logic [7:0] rx[$]);
        logic [7:0] b;
        int         n;
        n  = tx.size();
        rx = {};
        repeat (nrd) tx.push_back(8'h00);
        #37 cs_n = 1'b0;
        foreach (tx[i])
        begin
            for (int k = 7; k >= 0; k--)
            begin
                mosi = tx[i][k];
                #80 sck = 1'b1;
                b = {b[6:0], miso};
                #80 sck = 1'b0;
            end
            if (i >= n)
                rx.push_back(b);
        end
        #80 cs_n = 1'b1;
        mosi = ~mosi;
        #400;
    endtask : frame
endmodule : flash_host_model

// [bench/flash_status_config_regs_props.sv]
`timescale 1ns/1ps
module flash_status_config_regs_props #(
    parameter int BUSY_CYCLES = 3
) (
    input wire logic                    clk,
    input wire logic                    rst,
    input wire logic                    cs_n,
    input wire logic                    array_busy,
    input wire logic                    prog_fail,
    input wire logic                    erase_fail,
    input wire flash_regs_pkg::status_t status_out,
    input wire flash_regs_pkg::config_t config_out,
    input wire flash_regs_pkg::op_req_t op_req
);
    import flash_regs_pkg::*;
    // Slack of one cycle each way, since the counter load and the output register may skew
    localparam int BUSY_LO = BUSY_CYCLES - 1;
    localparam int BUSY_HI = BUSY_CYCLES + 1;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_prog_err_set: assert property (prog_fail |-> ##[1:3] status_out.prog_error)
        else $error("program failure not flagged");
    chk_erase_err_set: assert property (erase_fail |-> ##[1:3] status_out.erase_error)
        else $error("erase failure not flagged");
    chk_start_gated: assert property (op_req.start |-> status_out.write_enable_latch ##1 !op_req.start)
        else $error("operation start without write latch");
    chk_busy_array: assert property (array_busy [*3] |-> status_out.busy_flag)
        else $error("busy flag low while array works");
    chk_busy_length: assert property ($rose(status_out.busy_flag) && !array_busy
        |-> ##[BUSY_LO:BUSY_HI] !status_out.busy_flag)
        else $error("register write busy time wrong");
    chk_freeze_hold: assert property ($past(config_out.freeze_lock) && config_out.freeze_lock
        |-> $stable(status_out.protect_range) && $stable(config_out.protect_start_select))
        else $error("frozen protection bits changed");
    chk_otp_sticky: assert property ((($past(config_out) & 8'h2c) & ~config_out) == 8'h00)
        else $error("one-time bit cleared");
    chk_cfg_quiet: assert property (!$stable(config_out) |-> cs_n)
        else $error("config changed inside a frame");
endmodule : flash_status_config_regs_props

bind flash_status_config_regs flash_status_config_regs_props #(.BUSY_CYCLES(BUSY_CYCLES)) props (
    .clk, .rst, .cs_n, .array_busy, .prog_fail, .erase_fail, .status_out, .config_out, .op_req);

// [bench/serial_flash_status_config_regs_tb.sv]
`timescale 1ns/1ps
module serial_flash_status_config_regs_tb;
    import flash_regs_pkg::*;
    logic        clk, rst, wp_n, array_busy, prog_fail, erase_fail, sck, cs_n, mosi, miso;
    status_t     status_out;
    config_t     config_out;
    op_req_t     op_req;
    logic [23:0] op_addr, eaddr;
    logic [7:0]  est, ecf, rx[$];
    logic [31:0] r;
    int          n_fail, n_compared, seed, nstart, estart;

    flash_status_config_regs #(.BUSY_CYCLES(3)) DUT (.clk, .rst, .ce(1'b1), .sck, .cs_n, .mosi, .wp_n,
        .array_busy, .prog_fail, .erase_fail, .miso, .status_out, .config_out, .op_req, .op_addr);
    flash_host_model HOST (.sck, .cs_n, .mosi, .miso);

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
        if (op_req.start === 1'b1)
            nstart += op_req.erase ? 2 : 1;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test

    task automatic settle;
        int k;
        k = 0;
        repeat (4) @(negedge clk);
        while (status_out.busy_flag !== 1'b0 && k < 40)
        begin
            @(negedge clk);
            k++;
        end
        check(status_out, est);
        check(config_out, ecf);
        if (k == 40)
        begin
            n_fail++;
            end_of_test;
        end
    endtask : settle

    // Reference model; anything not listed is taken as program or erase
    task automatic cmd(input logic [7:0] tx[$]);
        logic frz;
        frz = ecf[0];
        HOST.frame(tx, 0, rx);
        case (tx[0])
            OP_SET_WRITE_LATCH:   est[1] = 1'b1;
            OP_CLEAR_WRITE_LATCH: est[1] = 1'b0;
            OP_CLEAR_STATUS:      est[6:5] = 2'b00;
            OP_SOFT_RESET:
            begin
                est[6:5] = 2'b00;
                ecf[0]   = 1'b0;
                if (ecf[3])
                    est[4:2] = 3'h7;
            end
            OP_REGISTER_WRITE:
                if (est[1] && !(est[7] && !wp_n))
                begin
                    est[7] = tx[1][7];
                    if (!frz)
                        est[4:2] = tx[1][4:2];
                    ecf = {tx[2][7:6], ecf[5] | (tx[2][5] & !frz), 1'b0, ecf[3] | tx[2][3],
                           ecf[2] | (tx[2][2] & !frz), tx[2][1], frz | tx[2][0]};
                end
            default:
                if (est[1] && est[4:2] == 3'h7)
                    est[tx[0] == OP_PAGE_PROGRAM ? 6 : 5] = 1'b1;
                else if (est[1])
                begin
                    estart += (tx[0] == OP_SECTOR_ERASE) ? 2 : 1;
                    eaddr = {tx[1], tx[2], tx[3]};
                end
        endcase
        settle;
    endtask : cmd

    task automatic rd(input logic [7:0] op, input logic [7:0] exp);
        HOST.frame({op}, 2, rx);
        check(rx[0], exp);
        check(rx[1], exp);
    endtask : rd

    initial
    begin
        {rst, wp_n, array_busy, prog_fail, erase_fail} = 5'b11000;
        seed = 32'h650f;
        est  = 8'h00;
        ecf  = 8'h00;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        check(status_out, 8'h00);
        check(config_out, 8'h00);
        rd(OP_READ_STATUS, 8'h00);
        cmd({OP_REGISTER_WRITE, 8'h1c, 8'h02});
        cmd({OP_SET_WRITE_LATCH});
        repeat (3)
        begin
            r = $random(seed);
            cmd({OP_REGISTER_WRITE, r[7:0] & 8'h1c, r[15:8] & 8'hc2});
            rd(OP_READ_CONFIG, ecf);
        end
        cmd({OP_REGISTER_WRITE, 8'h80, 8'h40});
        wp_n = 1'b0;
        cmd({OP_REGISTER_WRITE, 8'h1c, 8'h02});
        wp_n = 1'b1;
        cmd({OP_REGISTER_WRITE, 8'h00, 8'h00});
        HOST.frame({OP_READ_ID}, 23, rx);
        foreach (rx[i])
            check(rx[i], (i == 0 || i == 17) ? 8'hf0 : (i == 1) ? 8'h0f : (i == 18) ? 8'h03 : 8'hff);
        @(negedge clk) prog_fail = 1'b1;
        @(negedge clk) {prog_fail, erase_fail} = 2'b01;
        @(negedge clk) erase_fail = 1'b0;
        est[6:5] = 2'b11;
        settle;
        rd(OP_READ_STATUS, est);
        cmd({OP_CLEAR_STATUS});
        array_busy = 1'b1;
        repeat (4) @(negedge clk);
        check(status_out.busy_flag, 1'b1);
        array_busy = 1'b0;
        settle;
        r = $random(seed);
        cmd({r[24] ? OP_SECTOR_ERASE : OP_PAGE_PROGRAM, r[23:16], r[15:8], r[7:0]});
        check(op_addr, eaddr);
        cmd({OP_CLEAR_WRITE_LATCH});
        cmd({OP_PAGE_PROGRAM, 8'h00, 8'h10, 8'h00});
        cmd({OP_SET_WRITE_LATCH});
        cmd({OP_REGISTER_WRITE, 8'h1c, 8'h2d});
        cmd({OP_SECTOR_ERASE, 8'h01, 8'h00, 8'h00});
        cmd({OP_REGISTER_WRITE, 8'h00, 8'h00});
        cmd({OP_SOFT_RESET});
        cmd({OP_REGISTER_WRITE, 8'h08, 8'hc0});
        check(nstart, estart);
        end_of_test;
    end
endmodule : serial_flash_status_config_regs_tb
